// ### dacc_top.sv
// Control logic of the 8-bit resistor-string converter with its register slave.
// ****************************************************************************
// ****************************************************************************
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "dacc_params.svh"
module dacc_top (
   // Clock and reset.
   input wire logic i_core_clk,
   input wire logic i_rstn,
   // AXI4-Lite write address.
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data.
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response.
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address.
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data.
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Sleep requests and peripheral clock availability from the power manager, asynchronous levels.
   input wire logic i_standby_sleep,
   input wire logic i_powerdown_sleep,
   input wire logic i_clk_per_avail,
   // Analog core controls.
   output logic o_core_on,
   output logic o_internal_out_on,
   output logic o_buf_on,
   output logic o_start,
   output logic [7:0] o_code
);
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // ****************************************************************************
   // Register state
   // ****************************************************************************
   dacc_pkg::dacc_ctrl_t ctrl_q;
   logic [7:0] code_q;
   dacc_pkg::dacc_state_t state_q;
   dacc_pkg::dacc_analog_t ana_q;
   logic aw_got_q;
   logic w_got_q;
   logic [7:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic wr_fire;
   logic wr_ctrl;
   logic wr_code;
   logic pending_q;
   logic standby_lvl;
   logic powerdown_lvl;
   logic clk_avail_lvl;
   logic asleep;
   logic warm_load;
   logic warm_busy;
   logic [7:0] ctrl_rd;
   logic [7:0] status_rd;

   // ****************************************************************************
   // Pin input synchronisers
   // ****************************************************************************
   dacc_sync u_sync_stby (
      .i_core_clk(i_core_clk),
      .i_rstn(i_rstn),
      .i_async(i_standby_sleep),
      .o_level(standby_lvl)
   );
   dacc_sync u_sync_pdwn (
      .i_core_clk(i_core_clk),
      .i_rstn(i_rstn),
      .i_async(i_powerdown_sleep),
      .o_level(powerdown_lvl)
   );
   dacc_sync u_sync_clk (
      .i_core_clk(i_core_clk),
      .i_rstn(i_rstn),
      .i_async(i_clk_per_avail),
      .o_level(clk_avail_lvl)
   );

   dacc_timer #(
      .CYCLES(`DACC_STARTUP_CYC)
   ) u_warm (
      .i_core_clk(i_core_clk),
      .i_rstn(i_rstn),
      .i_load(warm_load),
      .o_busy(warm_busy)
   );

   // ****************************************************************************
   // AXI4-Lite write path
   // ****************************************************************************
   // Address and data are caught independently so the master may offer them in either order.
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         aw_got_q <= 1'b0;
         aw_addr_q <= 8'h00;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_got_q <= 1'b1;
         aw_addr_q <= s_axi_awaddr;
      end else if (wr_fire) begin
         aw_got_q <= 1'b0;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         w_got_q <= 1'b0;
         w_data_q <= 32'h00000000;
         w_strb_q <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_got_q <= 1'b1;
         w_data_q <= s_axi_wdata;
         w_strb_q <= s_axi_wstrb;
      end else if (wr_fire) begin
         w_got_q <= 1'b0;
      end
   end

   // Ready is a registered level, held off while a write waits for its response.
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_awready <= !aw_got_q && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
         s_axi_wready <= !w_got_q && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
      end
   end

   assign wr_fire = aw_got_q && w_got_q && !s_axi_bvalid;
   // Only byte lane 0 carries register bits; a write with lane 0 off stores nothing.
   assign wr_ctrl = wr_fire && (aw_addr_q[7:2] == 6'(`DACC_ADDR_CONTROL >> 2)) && w_strb_q[0];
   assign wr_code = wr_fire && (aw_addr_q[7:2] == 6'(`DACC_ADDR_CODE >> 2)) && w_strb_q[0];

   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         if (aw_addr_q[7:2] == 6'(`DACC_ADDR_CONTROL >> 2) ||
            aw_addr_q[7:2] == 6'(`DACC_ADDR_CODE >> 2)) begin
            s_axi_bresp <= RESP_OKAY;
         end else begin
            s_axi_bresp <= RESP_SLVERR;
         end
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ****************************************************************************
   // Registers
   // ****************************************************************************
   // Reset leaves the converter off with buffer and standby operation off.
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         ctrl_q <= '0;
      end else if (wr_ctrl) begin
         ctrl_q.enable <= w_data_q[`DACC_BIT_ENABLE];
         ctrl_q.pin_drive_on <= w_data_q[`DACC_BIT_PIN_DRIVE];
         ctrl_q.keep_alive <= w_data_q[`DACC_BIT_KEEP_ALIVE];
      end
   end

   // The code is stored whether or not the converter is on.
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         code_q <= `DACC_CODE_RESET;
      end else if (wr_code) begin
         code_q <= w_data_q[7:0];
      end
   end

   // ****************************************************************************
   // Power state
   // ****************************************************************************
   // Power-down always gates; standby gates unless kept alive with a running clock.
   assign asleep = powerdown_lvl ||
      (standby_lvl && !(ctrl_q.keep_alive && clk_avail_lvl));
   // Debug halt has no input here, so a halted CPU never disturbs the converter.
   assign warm_load = (state_q == dacc_pkg::DACC_ASLEEP) && !asleep && ctrl_q.enable;

   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         state_q <= dacc_pkg::DACC_OFF;
      end else begin
         unique case (state_q)
            dacc_pkg::DACC_OFF: begin
               if (ctrl_q.enable && asleep) begin
                  state_q <= dacc_pkg::DACC_ASLEEP;
               end else if (ctrl_q.enable) begin
                  state_q <= dacc_pkg::DACC_RUN;
               end
            end
            dacc_pkg::DACC_RUN: begin
               if (!ctrl_q.enable) begin
                  state_q <= dacc_pkg::DACC_OFF;
               end else if (asleep) begin
                  state_q <= dacc_pkg::DACC_ASLEEP;
               end
            end
            dacc_pkg::DACC_ASLEEP: begin
               if (!ctrl_q.enable) begin
                  state_q <= dacc_pkg::DACC_OFF;
               end else if (!asleep) begin
                  state_q <= dacc_pkg::DACC_WARMUP;
               end
            end
            dacc_pkg::DACC_WARMUP: begin
               if (!ctrl_q.enable) begin
                  state_q <= dacc_pkg::DACC_OFF;
               end else if (asleep) begin
                  state_q <= dacc_pkg::DACC_ASLEEP;
               end else if (!warm_busy && !warm_load) begin
                  state_q <= dacc_pkg::DACC_RUN;
               end
            end
         endcase
      end
   end

   // A launch asked for while asleep or warming waits and fires once running again.
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         pending_q <= 1'b0;
      end else if (!ctrl_q.enable) begin
         pending_q <= 1'b0;
      end else if (state_q == dacc_pkg::DACC_RUN) begin
         pending_q <= 1'b0;
      end else if (state_q == dacc_pkg::DACC_ASLEEP && !asleep) begin
         pending_q <= 1'b1;
      end else if (state_q != dacc_pkg::DACC_OFF && wr_code) begin
         pending_q <= 1'b1;
      end
   end

   // ****************************************************************************
   // Analog core outputs
   // ****************************************************************************
   // All outputs are registered so the analog macro sees glitch-free controls.
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         ana_q <= '0;
      end else begin
         ana_q.core_on <= (state_q != dacc_pkg::DACC_OFF) &&
            (state_q != dacc_pkg::DACC_ASLEEP) && !asleep;
         ana_q.buf_on <= (state_q != dacc_pkg::DACC_OFF) &&
            (state_q != dacc_pkg::DACC_ASLEEP) && !asleep && ctrl_q.pin_drive_on;
         ana_q.start <= ((state_q == dacc_pkg::DACC_RUN) && !asleep && ctrl_q.enable &&
            (wr_code || pending_q)) ||
            ((state_q == dacc_pkg::DACC_OFF) && ctrl_q.enable && !asleep);
         ana_q.code <= wr_code ? w_data_q[7:0] : code_q;
      end
   end

   assign o_core_on = ana_q.core_on;
   assign o_internal_out_on = ana_q.core_on;
   assign o_buf_on = ana_q.buf_on;
   assign o_start = ana_q.start;
   assign o_code = ana_q.code;

   // ****************************************************************************
   // AXI4-Lite read path
   // ****************************************************************************
   assign ctrl_rd = {ctrl_q.keep_alive, ctrl_q.pin_drive_on, 5'b00000, ctrl_q.enable};
   assign status_rd = {4'h0, warm_busy, pending_q, ana_q.buf_on, ana_q.core_on};

   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_rvalid) begin
         if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= RESP_OKAY;
         unique case (s_axi_araddr[7:2])
            6'(`DACC_ADDR_CONTROL >> 2): s_axi_rdata <= {24'h000000, ctrl_rd};
            6'(`DACC_ADDR_CODE >> 2): s_axi_rdata <= {24'h000000, code_q};
            6'(`DACC_ADDR_STATUS >> 2): s_axi_rdata <= {24'h000000, status_rd};
            default: begin
               s_axi_rdata <= 32'h00000000;
               s_axi_rresp <= RESP_SLVERR;
            end
         endcase
      end else begin
         s_axi_arready <= 1'b1;
      end
   end

   // ****************************************************************************
   // Assertions
   // ****************************************************************************
   a_start_single: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      o_start |=> !o_start) else $error("Start pulse longer than one clock.");
   a_code_launch: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      (wr_code && state_q == dacc_pkg::DACC_RUN && ctrl_q.enable && !asleep)
      |=> o_start && o_code == $past(w_data_q[7:0])) else $error("Code write did not launch.");
   a_off_no_start: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      (!ctrl_q.enable && $past(!ctrl_q.enable)) |=> !o_start) else $error("Start while off.");
   a_enable_start: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      (state_q == dacc_pkg::DACC_OFF && ctrl_q.enable && !asleep) |=> o_start && o_code == code_q)
      else $error("Enable did not convert stored code.");
   a_buf_needs_pin: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      o_buf_on |-> o_core_on && $past(ctrl_q.pin_drive_on))
      else $error("Buffer on without pin drive.");
   a_pdwn_gates: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      powerdown_lvl |=> !o_core_on && !o_buf_on) else $error("Converter on in power-down.");
   a_stby_gates: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      (standby_lvl && !ctrl_q.keep_alive) |=> !o_core_on && !o_start)
      else $error("Standby not gated.");
   a_stby_keep: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      (state_q == dacc_pkg::DACC_RUN && ctrl_q.enable && !powerdown_lvl && ctrl_q.keep_alive
      && clk_avail_lvl) |=> o_core_on) else $error("Kept-alive converter turned off.");
   a_wake_warmup: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      (state_q == dacc_pkg::DACC_ASLEEP && !asleep && ctrl_q.enable) |=> !o_start [*2])
      else $error("Conversion before start-up interval.");
   a_ctrl_zero: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      ctrl_rd[5:1] == 5'b00000) else $error("Unused control bits not zero.");

   c_code_launch: cover property (@(posedge i_core_clk) disable iff (!i_rstn)
      wr_code ##1 o_start);
   c_wake: cover property (@(posedge i_core_clk) disable iff (!i_rstn)
      state_q == dacc_pkg::DACC_WARMUP ##1 state_q == dacc_pkg::DACC_RUN);
   c_pin: cover property (@(posedge i_core_clk) disable iff (!i_rstn) o_buf_on);
endmodule
`default_nettype wire

// ### dacc_params.svh
// Register offsets, field positions, reset values and timing counts of the converter control.
`ifndef DACC_PARAMS_SVH
`define DACC_PARAMS_SVH
// Register indices; the byte address on the bus is four times the index.
`define DACC_IDX_CONTROL 8'h00
`define DACC_IDX_CODE 8'h01
`define DACC_IDX_STATUS 8'h02
`define DACC_ADDR_CONTROL 8'h00
`define DACC_ADDR_CODE 8'h04
`define DACC_ADDR_STATUS 8'h08
`define DACC_BIT_ENABLE 0
`define DACC_BIT_PIN_DRIVE 6
`define DACC_BIT_KEEP_ALIVE 7
`define DACC_CONTROL_MASK 8'hc1
`define DACC_CONTROL_RESET 8'h00
`define DACC_CODE_RESET 8'h00
`define DACC_CLK_PERIOD_NS 20
`define DACC_STARTUP_NS 1000
`define DACC_STARTUP_CYC ((`DACC_STARTUP_NS + `DACC_CLK_PERIOD_NS - 1) / `DACC_CLK_PERIOD_NS)
`endif

// ### dacc_pkg.sv
// Types shared by the converter control files.
`default_nettype none
package dacc_pkg;
   typedef enum logic [1:0] {DACC_OFF, DACC_WARMUP, DACC_RUN, DACC_ASLEEP} dacc_state_t;
   typedef struct packed {
      logic keep_alive;
      logic pin_drive_on;
      logic enable;
   } dacc_ctrl_t;
   typedef struct packed {
      logic core_on;
      logic buf_on;
      logic start;
      logic [7:0] code;
   } dacc_analog_t;
endpackage
`default_nettype wire

// ### dacc_sync.sv
// Three-stage synchroniser with agreement filter for one pin level.
`timescale 1ns/100ps
`default_nettype none
module dacc_sync (
   // Clock and reset.
   input wire logic i_core_clk,
   input wire logic i_rstn,
   // Asynchronous level in, filtered level out.
   input wire logic i_async,
   output logic o_level
);
   logic s1_q;
   logic s2_q;
   logic s3_q;

   // The first stage feeds only the second; a change counts once stages two and three agree.
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         o_level <= 1'b0;
      end else begin
         s1_q <= i_async;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q) begin
            o_level <= s3_q;
         end
      end
   end
endmodule
`default_nettype wire

// ### dacc_timer.sv
// Down counter that times the converter start-up interval.
`timescale 1ns/100ps
`default_nettype none
module dacc_timer #(
   parameter int unsigned CYCLES = 50
) (
   // Clock and reset.
   input wire logic i_core_clk,
   input wire logic i_rstn,
   // Load and status.
   input wire logic i_load,
   output logic o_busy
);
   logic [15:0] cnt_q;

   // Load restarts the full interval; busy stays high until the count runs out.
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         cnt_q <= 16'h0000;
      end else if (i_load) begin
         cnt_q <= 16'(CYCLES);
      end else if (cnt_q != 16'h0000) begin
         cnt_q <= cnt_q - 16'h0001;
      end
   end

   assign o_busy = (cnt_q != 16'h0000);
endmodule
`default_nettype wire

// ### dacc_analog_model.sv
// Behavioural model of the analog core, resistor string and pin buffer.
`timescale 1ns/100ps
`default_nettype none
module dacc_analog_model (
   // Clock and reset.
   input wire logic i_core_clk,
   input wire logic i_rstn,
   // Controls from the block.
   input wire logic i_core_on,
   input wire logic i_buf_on,
   input wire logic i_start,
   input wire logic [7:0] i_code,
   // Observed analog state.
   output logic [15:0] o_starts,
   output logic [7:0] o_level,
   output logic [7:0] o_pin
);
   // ***************************************************************
   // Resistor string
   // ***************************************************************
   // Every start cycle is counted, so a pulse held for two cycles shows as two.
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_starts <= 16'h0000;
         o_level <= 8'h00;
      end else if (i_start) begin
         o_starts <= o_starts + 16'h0001;
         o_level <= i_code;
      end
   end
   // A pad whose buffer is off floats, so show the inverse rather than a stale match.
   assign o_pin = (i_buf_on && i_core_on) ? o_level : ~o_level;
endmodule
`default_nettype wire

// ### test_dac_control_logic.sv
// Self-checking bench for the converter control block.
`timescale 1ns/100ps
`default_nettype none
`include "dacc_params.svh"
module test_dac_control_logic;
   // ***************************************************************
   // Signals, clock and bus tasks
   // ***************************************************************
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic stby = 1'b0;
   logic pdn = 1'b0;
   logic clkav = 1'b1;
   logic awready, wready, bvalid, arready, rvalid, core_on, int_on, buf_on, start;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [7:0] code, level, pin;
   logic [15:0] starts;
   int n_fail = 0;
   int total_checks = 0;
   // Free-running 50 MHz clock.
   always #10 clk = ~clk;
   dacc_top DUT (.i_core_clk(clk), .i_rstn(rstn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .i_standby_sleep(stby), .i_powerdown_sleep(pdn),
      .i_clk_per_avail(clkav), .o_core_on(core_on), .o_internal_out_on(int_on),
      .o_buf_on(buf_on), .o_start(start), .o_code(code));
   dacc_analog_model far_side (.i_core_clk(clk), .i_rstn(rstn), .i_core_on(core_on),
      .i_buf_on(buf_on), .i_start(start), .i_code(code), .o_starts(starts),
      .o_level(level), .o_pin(pin));
   // Prints the counts and the verdict, then ends the run.
   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // Compares a value with four-state equality so an unknown never matches.
   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One write; the address and data are released each as it is taken.
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      logic done;
      n = 0;
      done = 1'b0;
      @(posedge clk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!done && n < 100) begin
         @(posedge clk);
         n++;
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid && bready) begin
            done = 1'b1;
            bready <= 1'b0;
            chk_val({30'h0, bresp}, {30'h0, er});
         end
      end
      chk_val({31'h0, done}, 32'h1);
   endtask
   // One read; data and response are taken at the edge that shows rvalid.
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      logic done;
      n = 0;
      done = 1'b0;
      d = 32'hxxxxxxxx;
      r = 2'bxx;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!done && n < 100) begin
         @(posedge clk);
         n++;
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid && rready) begin
            done = 1'b1;
            d = rdata;
            r = rresp;
            rready <= 1'b0;
         end
      end
   endtask
   // Waits, bounded, until the far side has counted the given number of starts.
   task automatic wait_start(input logic [15:0] target, output int cyc);
      cyc = 0;
      while (starts !== target && cyc < 200) begin
         @(posedge clk);
         cyc++;
      end
   endtask
   // ***************************************************************
   // Scenarios
   // ***************************************************************
   // Reset values, reserved control bits and an unmapped address.
   task automatic t_regs();
      logic [31:0] d;
      logic [1:0] r;
      axi_rd(`DACC_ADDR_CONTROL, d, r);
      chk_val(d, 32'h0);
      axi_rd(`DACC_ADDR_CODE, d, r);
      chk_val(d, 32'h0);
      axi_wr(`DACC_ADDR_CONTROL, 32'h3e, 2'b00);
      axi_rd(`DACC_ADDR_CONTROL, d, r);
      chk_val(d, 32'h0);
      chk_val({31'h0, core_on}, 32'h0);
      axi_wr(8'h0c, 32'h1, 2'b10);
      axi_rd(8'h0c, d, r);
      chk_val({d[29:0], r}, 32'h2);
   endtask
   // Code written while off is stored, then converted when enable is set.
   task automatic t_store_then_enable();
      logic [31:0] d;
      logic [1:0] r;
      logic [15:0] s;
      int cyc;
      s = starts;
      axi_wr(`DACC_ADDR_CODE, 32'ha5, 2'b00);
      repeat (6) @(posedge clk);
      chk_val({16'h0, starts}, {16'h0, s});
      axi_rd(`DACC_ADDR_CODE, d, r);
      chk_val(d, 32'ha5);
      axi_wr(`DACC_ADDR_CONTROL, 32'h01, 2'b00);
      wait_start(s + 16'h1, cyc);
      repeat (3) @(posedge clk);
      chk_val({8'h0, starts, level}, {8'h0, s + 16'h1, 8'ha5});
      chk_val({29'h0, core_on, int_on, buf_on}, 32'h6);
      chk_val({24'h0, pin}, 32'h5a);
      // Status shows the core on, buffer off, nothing pending and no start-up running.
      axi_rd(`DACC_ADDR_STATUS, d, r);
      chk_val({d[29:0], r}, 32'h4);
   endtask
   // Every code write while on converts the full byte, one pulse each.
   task automatic t_run_writes();
      logic [7:0] codes [3] = '{8'h00, 8'hff, 8'h5a};
      logic [15:0] s;
      int cyc;
      foreach (codes[i]) begin
         s = starts;
         axi_wr(`DACC_ADDR_CODE, {24'hffffff, codes[i]}, 2'b00);
         wait_start(s + 16'h1, cyc);
         repeat (3) @(posedge clk);
         chk_val({16'h0, starts}, {16'h0, s + 16'h1});
         chk_val({24'h0, level}, {24'h0, codes[i]});
      end
   endtask
   // Pin buffer on, then standby without keep-alive and the wake-up start.
   task automatic t_standby_off();
      logic [15:0] s;
      int cyc;
      axi_wr(`DACC_ADDR_CONTROL, 32'h41, 2'b00);
      repeat (4) @(posedge clk);
      chk_val({23'h0, buf_on, pin}, {23'h0, 1'b1, level});
      stby <= 1'b1;
      repeat (12) @(posedge clk);
      chk_val({30'h0, core_on, buf_on}, 32'h0);
      s = starts;
      stby <= 1'b0;
      wait_start(s + 16'h1, cyc);
      chk_val({31'h0, (cyc - `DACC_STARTUP_CYC) inside {[0:12]}}, 32'h1);
      repeat (3) @(posedge clk);
      chk_val({30'h0, core_on, buf_on}, 32'h3);
   endtask
   // Keep-alive holds the core in standby; power-down still turns it off.
   task automatic t_standby_keep();
      logic [15:0] s;
      int cyc;
      axi_wr(`DACC_ADDR_CONTROL, 32'hc1, 2'b00);
      stby <= 1'b1;
      repeat (12) @(posedge clk);
      chk_val({30'h0, core_on, buf_on}, 32'h3);
      s = starts;
      axi_wr(`DACC_ADDR_CODE, 32'h3c, 2'b00);
      wait_start(s + 16'h1, cyc);
      chk_val({24'h0, level}, 32'h3c);
      pdn <= 1'b1;
      repeat (12) @(posedge clk);
      chk_val({30'h0, core_on, buf_on}, 32'h0);
      pdn <= 1'b0;
      stby <= 1'b0;
      repeat (80) @(posedge clk);
   endtask
   // Disable turns the core off and later code writes only store.
   task automatic t_disable();
      logic [15:0] s;
      axi_wr(`DACC_ADDR_CONTROL, 32'h00, 2'b00);
      s = starts;
      repeat (4) @(posedge clk);
      chk_val({30'h0, core_on, int_on}, 32'h0);
      axi_wr(`DACC_ADDR_CODE, 32'h11, 2'b00);
      repeat (6) @(posedge clk);
      chk_val({16'h0, starts}, {16'h0, s});
   endtask
   // Main sequence: ten cycles of reset, then the scenarios.
   initial begin
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      t_regs();
      t_store_then_enable();
      t_run_writes();
      t_standby_off();
      t_standby_keep();
      t_disable();
      close_out();
   end
   // Watchdog well beyond the expected run of under two thousand cycles.
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      close_out();
   end
endmodule
`default_nettype wire
